// ### inc/readout_pkg.sv
// shared constants and types of the converter result readout port
package readout_pkg;

   // result set geometry
   localparam int CHANNELS      = 8;
   localparam int WORD_W        = 16;
   localparam int BYTE_W        = 8;
   localparam int PTR_W         = 4;
   localparam int SER_POS_W     = 7;
   localparam int FLAG_CNT_W    = 5;
   // falling sclk edges that end the first word
   localparam logic [FLAG_CNT_W-1:0] FLAG_EDGES = 5'h10;
   // second serial line starts this many channels further on
   localparam logic [2:0] SECOND_LINE_OFS = 3'h4;

   // conversion time, longest figure rounded down, at least one cycle
   localparam int CLK_PERIOD_NS = 25;
   localparam int CONV_TIME_NS  = 4000;
   localparam int CONV_CYCLES   = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                  : CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_CNT_W    = $clog2(CONV_CYCLES + 1);

   // bus enables and reset values
   localparam logic [WORD_W-1:0] DB_ALL_OE  = 16'hffff;
   localparam logic [WORD_W-1:0] DB_LOW_OE  = 16'h00ff;
   localparam logic [WORD_W-1:0] DB_OFF     = 16'h0000;
   localparam logic [PTR_W-1:0]  PTR_FIRST  = 4'h0;

   typedef logic [CHANNELS-1:0][WORD_W-1:0] result_set_type;

   typedef enum logic [1:0] {
      mode_word,
      mode_serial,
      mode_byte
   } readout_mode_type;

   // host pins that are sampled in the core clock domain
   typedef struct packed {
      logic conv;
      logic cs_n;
      logic rd_n;
      logic iface;
      logic bsel;
      logic hbf;
   } pins_type;

   // idle pin levels: strobes high, everything else low
   localparam pins_type PINS_IDLE = 6'h18;

endpackage

// ### logic/adc_result_readout_port.sv
// result readout port: word, byte and serial modes with busy handshake
`timescale 1ns/100ps

// Functional notes
// - two select pins choose the readout mode
// - parallel bus driven only with both strobes low
// - chip select rise floats and releases the bus
// - each read fall presents next channel, ascending
// - tied strobes: each fall presents next channel
// - byte mode: two transfers per channel
// - byte mode uses low eight lines only
// - line 14 picks high byte first
// - byte mode flag holds through both bytes
// - first line channels 1-4, second 5-8
// - select fall shows msb, sclk rise shifts
// - second line alone gives 5-8 then 1-4
// - flag floats while select high, set on fall
// - serial flag low after sixteenth falling edge
// - second line only: flag marks channel 5 word
// - busy rises on start, falls at end
module adc_result_readout_port (
   input  wire logic                        core_clk,
   input  wire logic                        srst,
   input  wire logic                        sclk,
   input  wire logic                        cs_n,
   input  wire logic                        rd_n,
   input  wire logic                        conversion_start,
   input  wire logic                        interface_select,
   input  wire logic                        byte_mode_select,
   input  wire logic                        high_byte_first,
   input  wire readout_pkg::result_set_type channel_result,
   output logic [readout_pkg::WORD_W-1:0]   db_out,
   output logic [readout_pkg::WORD_W-1:0]   db_oe,
   output logic                             serial_out_first,
   output logic                             serial_out_first_oe,
   output logic                             serial_out_second,
   output logic                             serial_out_second_oe,
   output logic                             first_channel_flag,
   output logic                             first_channel_flag_oe,
   output logic                             busy
);

   readout_pkg::pins_type                   pin_raw;
   readout_pkg::pins_type                   sync1_r;
   readout_pkg::pins_type                   sync2_r;
   readout_pkg::pins_type                   prev_r;
   readout_pkg::readout_mode_type           mode_r;
   readout_pkg::result_set_type             results_r;
   logic [readout_pkg::CONV_CNT_W-1:0]      conv_cnt_r;
   logic                                    busy_r;
   logic                                    set_start_r;
   logic [readout_pkg::PTR_W-1:0]           ptr_r;
   logic [readout_pkg::WORD_W-1:0]          data_r;
   logic [readout_pkg::WORD_W-1:0]          db_oe_r;
   logic                                    flag_par_r;
   logic                                    flag_oe_r;
   logic                                    conv_rise;
   logic                                    busy_fall;
   logic                                    rd_fall;
   logic                                    ser_first;
   logic                                    ser_second;
   logic                                    ser_flag;

   // select pins to mode; the undefined combination falls back to word mode
   function automatic readout_pkg::readout_mode_type decode_mode(input logic iface,
                                                                 input logic bsel);
      if (iface && bsel) begin
         decode_mode = readout_pkg::mode_byte;
      end else if (iface) begin
         decode_mode = readout_pkg::mode_serial;
      end else begin
         decode_mode = readout_pkg::mode_word;
      end
   endfunction

   // one byte of a result, upper or lower
   function automatic logic [readout_pkg::BYTE_W-1:0] pick_byte(
      input logic [readout_pkg::WORD_W-1:0] w,
      input logic                           upper);
      pick_byte = upper ? w[15:8] : w[7:0];
   endfunction

   assign pin_raw = {conversion_start, cs_n, rd_n, interface_select,
                     byte_mode_select, high_byte_first};

   // two-flop synchronisers for every host pin except sclk, plus an edge history
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1_r <= readout_pkg::PINS_IDLE;
         sync2_r <= readout_pkg::PINS_IDLE;
         prev_r  <= readout_pkg::PINS_IDLE;
      end else begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign conv_rise = !prev_r.conv && sync2_r.conv;
   // a read strobe only counts while chip select is low
   assign rd_fall   = prev_r.rd_n && !sync2_r.rd_n && !sync2_r.cs_n;
   assign busy_fall = busy_r && (conv_cnt_r == '0);

   // mode follows the static select pins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mode_r <= readout_pkg::mode_word;
      end else begin
         mode_r <= decode_mode(sync2_r.iface, sync2_r.bsel);
      end
   end

   // busy from start edge to end of conversion time
   always_ff @(posedge core_clk) begin
      if (srst) begin
         busy_r     <= 1'b0;
         conv_cnt_r <= '0;
      end else if (!busy_r && conv_rise) begin
         busy_r     <= 1'b1;
         conv_cnt_r <= readout_pkg::CONV_CNT_W'(readout_pkg::CONV_CYCLES - 1);
      end else if (busy_fall) begin
         busy_r     <= 1'b0;
      end else if (busy_r) begin
         conv_cnt_r <= conv_cnt_r - 1'b1;
      end
   end

   // output registers load at busy fall; older data is readable while busy
   always_ff @(posedge core_clk) begin
      if (srst) begin
         results_r <= '0;
      end else if (busy_fall) begin
         results_r <= channel_result;
      end
   end

   // clears the serial position; held through reset so the shifter starts clean
   always_ff @(posedge core_clk) begin
      if (srst) begin
         set_start_r <= 1'b1;
      end else begin
         set_start_r <= busy_fall;
      end
   end

   // readout pointer: channel in word mode, channel and half in byte mode
   always_ff @(posedge core_clk) begin
      if (srst || busy_fall) begin
         ptr_r <= readout_pkg::PTR_FIRST;
      end else if (rd_fall && mode_r != readout_pkg::mode_serial) begin
         ptr_r <= ptr_r + 4'h1;
      end
   end

   // data and flag latched on each read fall in word and byte modes
   always_ff @(posedge core_clk) begin
      if (srst) begin
         data_r     <= '0;
         flag_par_r <= 1'b0;
      end else if (rd_fall && mode_r == readout_pkg::mode_byte) begin
         data_r     <= {8'h00, pick_byte(results_r[ptr_r[3:1]],
                                         ptr_r[0] ^ sync2_r.hbf)};
         flag_par_r <= (ptr_r[3:1] == 3'h0);
      end else if (rd_fall && mode_r == readout_pkg::mode_word) begin
         data_r     <= results_r[ptr_r[2:0]];
         flag_par_r <= (ptr_r[2:0] == 3'h0);
      end
   end

   // bus enables: both strobes low, parallel modes only
   always_ff @(posedge core_clk) begin
      if (srst) begin
         db_oe_r   <= readout_pkg::DB_OFF;
         flag_oe_r <= 1'b0;
      end else begin
         flag_oe_r <= !sync2_r.cs_n;
         if (sync2_r.cs_n || sync2_r.rd_n || mode_r == readout_pkg::mode_serial) begin
            db_oe_r <= readout_pkg::DB_OFF;
         end else if (mode_r == readout_pkg::mode_byte) begin
            db_oe_r <= readout_pkg::DB_LOW_OE;
         end else begin
            db_oe_r <= readout_pkg::DB_ALL_OE;
         end
      end
   end

   // serial side lives on sclk; words are quiet except at busy fall
   serial_result_shifter u_shift (
      .sclk        (sclk),
      .clear       (set_start_r),
      .results     (results_r),
      .dout_first  (ser_first),
      .dout_second (ser_second),
      .flag        (ser_flag)
   );

   // serial pins follow chip select directly: no core edge is needed
   // before the msb, at the cost of an unregistered path
   assign serial_out_first      = ser_first;
   assign serial_out_second     = ser_second;
   assign serial_out_first_oe   = (mode_r == readout_pkg::mode_serial) && !cs_n;
   assign serial_out_second_oe  = (mode_r == readout_pkg::mode_serial) && !cs_n;
   assign first_channel_flag    = (mode_r == readout_pkg::mode_serial) ? ser_flag
                                                                        : flag_par_r;
   assign first_channel_flag_oe = (mode_r == readout_pkg::mode_serial) ? !cs_n
                                                                        : flag_oe_r;
   assign db_out                = data_r;
   assign db_oe                 = db_oe_r;
   assign busy                  = busy_r;

   // checks on the core-clock logic
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   sequence s_start;
      !busy_r && conv_rise;
   endsequence

   sequence s_done;
      busy_r && conv_cnt_r == '0;
   endsequence

   a_busy_start_rise: assert property (s_start |=> busy_r)
      else $error("busy did not rise after start");

   a_busy_end_fall: assert property (s_done |=> !busy_r && ptr_r == readout_pkg::PTR_FIRST
                                     && set_start_r)
      else $error("busy end did not restart the set");

   a_result_load: assert property (s_done |=> results_r == $past(channel_result))
      else $error("results not loaded at busy fall");

   a_mode_decode: assert property (sync2_r.iface && !sync2_r.bsel
                                   |=> mode_r == readout_pkg::mode_serial)
      else $error("serial mode not selected");

   a_bus_gate: assert property (db_oe_r != readout_pkg::DB_OFF
                                |-> $past(!sync2_r.cs_n && !sync2_r.rd_n))
      else $error("bus driven without both strobes low");

   a_cs_float: assert property ($rose(sync2_r.cs_n) |=> db_oe_r == readout_pkg::DB_OFF)
      else $error("bus still driven after select rise");

   a_ptr_step: assert property (rd_fall && !busy_fall && mode_r != readout_pkg::mode_serial
                                |=> ptr_r == $past(ptr_r) + 4'h1)
      else $error("read fall did not advance pointer");

   a_word_first: assert property (rd_fall && !busy_fall && ptr_r == readout_pkg::PTR_FIRST
                                  && mode_r == readout_pkg::mode_word
                                  |=> data_r == results_r[0] && flag_par_r)
      else $error("first read is not channel one");

   a_byte_lanes: assert property (mode_r == readout_pkg::mode_byte
                                  |-> db_oe_r[15:8] == 8'h00)
      else $error("upper lines driven in byte mode");

   a_byte_order: assert property (rd_fall && !busy_fall && ptr_r == readout_pkg::PTR_FIRST
                                  && mode_r == readout_pkg::mode_byte && sync2_r.hbf
                                  |=> data_r[7:0] == results_r[0][15:8])
      else $error("high byte not first");

   a_byte_flag: assert property (rd_fall && !busy_fall && ptr_r == 4'h1
                                 && mode_r == readout_pkg::mode_byte
                                 |=> flag_par_r ##1 !rd_fall [*1] ##0 flag_par_r)
      else $error("flag dropped before second byte");

endmodule // adc_result_readout_port

// ### logic/serial_result_shifter.sv
// serial shifter running on the host serial clock
`timescale 1ns/100ps
module serial_result_shifter (
   input  wire logic                     sclk,
   input  wire logic                     clear,
   input  wire readout_pkg::result_set_type results,
   output logic                          dout_first,
   output logic                          dout_second,
   output logic                          flag
);

   logic [readout_pkg::SER_POS_W-1:0]  pos_r;
   logic [readout_pkg::FLAG_CNT_W-1:0] fall_cnt_r;
   logic [2:0]                         ch_first;
   logic [2:0]                         ch_second;

   // bit of a word counted from the msb
   function automatic logic msb_bit(input logic [readout_pkg::WORD_W-1:0] w,
                                    input logic [3:0] idx);
      msb_bit = w[4'hf - idx];
   endfunction

   // rising edges count the bits; chip select does not clear this,
   // so per-channel framing and one long frame both keep their place
   always_ff @(posedge sclk or posedge clear) begin
      if (clear) begin
         pos_r <= '0;
      end else begin
         pos_r <= pos_r + 7'h01;
      end
   end

   // falling edges end the first word for the flag
   always_ff @(negedge sclk or posedge clear) begin
      if (clear) begin
         fall_cnt_r <= '0;
      end else if (fall_cnt_r != readout_pkg::FLAG_EDGES) begin
         fall_cnt_r <= fall_cnt_r + 5'h01;
      end
   end

   // words are static between set starts, so no sync is needed here
   assign ch_first    = pos_r[6:4];
   assign ch_second   = pos_r[6:4] + readout_pkg::SECOND_LINE_OFS;
   assign dout_first  = msb_bit(results[ch_first], pos_r[3:0]);
   assign dout_second = msb_bit(results[ch_second], pos_r[3:0]);
   assign flag        = (fall_cnt_r != readout_pkg::FLAG_EDGES);

endmodule // serial_result_shifter

// ### test/host_model.sv
// host model: chip select, read strobe, serial clock and conversion start
`timescale 1ns/100ps
module host_model (
   input  wire logic core_clk,
   input  wire logic busy,
   output logic      cs_n,
   output logic      rd_n,
   output logic      sclk,
   output logic      conversion_start
);
   // idle: strobes high, serial clock parked high between frames
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      sclk = 1'b1;
      conversion_start = 1'b0;
   end

   // pulse start, count busy-high cycles, then keep clear of the busy fall
   task automatic convert(output int n);
      n = 0;
      @(negedge core_clk);
      conversion_start = 1'b1;
      for (int k = 0; k < 1000 && !(n > 0 && busy === 1'b0); k++) begin
         @(negedge core_clk);
         if (k == 3) conversion_start = 1'b0;
         if (busy === 1'b1) n++;
      end
      repeat (3) @(negedge core_clk);
   endtask

   // move read strobe, and chip select with it when the two are tied
   task automatic strobe(input bit lvl, input bit tied);
      @(negedge core_clk);
      rd_n = lvl;
      if (tied) cs_n = lvl;
      repeat (5) @(negedge core_clk); // held well past the sync delay
   endtask

   // chip select framing, for one long frame or one frame per channel
   task automatic sel(input bit lvl);
      @(negedge core_clk);
      cs_n = lvl;
      repeat (5) @(negedge core_clk);
   endtask

   // one serial clock of 160 ns; bench samples just before the fall
   task automatic tick();
      #1 sclk = 1'b0;
      #80 sclk = 1'b1;
      #79;
   endtask
endmodule // host_model

// ### test/testbench.sv
// self-checking bench for the result readout port
`timescale 1ns/100ps
module testbench;
   logic                          core_clk;
   logic                          srst;
   logic                          interface_select;
   logic                          byte_mode_select;
   logic                          high_byte_first;
   readout_pkg::result_set_type   channel_result;
   logic [15:0]                   db_out;
   logic [15:0]                   db_oe;
   logic                          serial_out_first;
   logic                          serial_out_first_oe;
   logic                          serial_out_second;
   logic                          serial_out_second_oe;
   logic                          first_channel_flag;
   logic                          first_channel_flag_oe;
   logic                          busy;
   logic                          cs_n;
   logic                          rd_n;
   logic                          sclk;
   logic                          conversion_start;
   int                            n_fail;
   int                            comparisons;

   adc_result_readout_port adc_result_readout_port_inst (
      .core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .rd_n(rd_n),
      .conversion_start(conversion_start), .interface_select(interface_select),
      .byte_mode_select(byte_mode_select), .high_byte_first(high_byte_first),
      .channel_result(channel_result), .db_out(db_out), .db_oe(db_oe),
      .serial_out_first(serial_out_first), .serial_out_first_oe(serial_out_first_oe),
      .serial_out_second(serial_out_second), .serial_out_second_oe(serial_out_second_oe),
      .first_channel_flag(first_channel_flag), .first_channel_flag_oe(first_channel_flag_oe),
      .busy(busy)
   );

   host_model host_model_inst (
      .core_clk(core_clk), .busy(busy), .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk),
      .conversion_start(conversion_start)
   );

   // core clock, 25 ns period
   always #12.5 core_clk = ~core_clk;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one read strobe, checked while low; upper lines masked by the enables
   task automatic rd(input bit tied, input logic [15:0] exp, input logic [15:0] oe, input bit fl);
      host_model_inst.strobe(1'b0, tied);
      chk("db_out", exp, db_out & oe);
      chk("db_oe", oe, db_oe);
      chk("flag", fl, first_channel_flag);
      chk("flag_oe", 1'b1, first_channel_flag_oe);
      host_model_inst.strobe(1'b1, tied);
   endtask

   // fresh result set, then a full conversion; results land at busy fall
   task automatic load(input int s);
      int n;
      for (int k = 0; k < 8; k++) channel_result[k] = 16'h1234 + 16'(k) * 16'h1111 + 16'(s);
      host_model_inst.convert(n);
      chk("busy_cycles", readout_pkg::CONV_CYCLES, n);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // main sequence: reset, word, tied, byte and serial reads
   initial begin
      logic [15:0] w;
      bit          up;
      n_fail = 0;
      comparisons = 0;
      core_clk = 1'b0;
      srst = 1'b1;
      interface_select = 1'b0;
      byte_mode_select = 1'b0;
      high_byte_first = 1'b0;
      channel_result = '0;
      repeat (8) @(negedge core_clk);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("db_oe", 16'h0000, db_oe);
      chk("busy", 1'b0, busy);
      // word mode: ascending channels, ninth read wraps to channel 1
      load(1);
      host_model_inst.sel(1'b0);
      for (int k = 0; k < 9; k++) rd(1'b0, channel_result[k % 8], 16'hffff, k % 8 == 0);
      host_model_inst.sel(1'b1);
      chk("db_oe", 16'h0000, db_oe);
      $display("test word done");
      // tied strobes after a fresh conversion restart at channel 1
      load(2);
      for (int k = 0; k < 3; k++) begin
         rd(1'b1, channel_result[k], 16'hffff, k == 0);
         chk("db_oe", 16'h0000, db_oe);
      end
      $display("test tied done");
      // byte mode, both byte orders, sixteen reads each
      @(negedge core_clk);
      interface_select = 1'b1;
      byte_mode_select = 1'b1;
      for (int h = 1; h >= 0; h--) begin
         high_byte_first = h[0];
         load(3 + h);
         host_model_inst.sel(1'b0);
         for (int j = 0; j < 16; j++) begin
            w = channel_result[j / 2];
            up = ((j % 2) == 0) == (h == 1);
            rd(1'b0, up ? {8'h00, w[15:8]} : {8'h00, w[7:0]}, 16'h00ff, j < 2);
         end
         host_model_inst.sel(1'b1);
      end
      $display("test byte done");
      // serial mode: 128 clocks in one frame, both lines watched
      @(negedge core_clk);
      byte_mode_select = 1'b0;
      load(5);
      chk("flag_oe", 1'b0, first_channel_flag_oe);
      host_model_inst.sel(1'b0);
      chk("sdo_oe", 2'b11, {serial_out_first_oe, serial_out_second_oe});
      chk("flag_oe", 1'b1, first_channel_flag_oe);
      for (int i = 0; i < 128; i++) begin
         chk("sdo_a", channel_result[i / 16][15 - i % 16], serial_out_first);
         chk("sdo_b", channel_result[(i / 16 + 4) % 8][15 - i % 16], serial_out_second);
         chk("flag", i < 16, first_channel_flag);
         host_model_inst.tick();
      end
      // a read strobe in serial mode must leave the parallel bus floating
      host_model_inst.strobe(1'b0, 1'b0);
      chk("db_oe", 16'h0000, db_oe);
      host_model_inst.strobe(1'b1, 1'b0);
      host_model_inst.sel(1'b1);
      chk("flag_oe", 1'b0, first_channel_flag_oe);
      chk("sdo_oe", 2'b00, {serial_out_first_oe, serial_out_second_oe});
      // both lines, each channel framed by its own select pulse
      load(6);
      for (int i = 0; i < 64; i++) begin
         if (i % 16 == 0) host_model_inst.sel(1'b0);
         chk("sdo_a", channel_result[i / 16][15 - i % 16], serial_out_first);
         chk("sdo_b", channel_result[i / 16 + 4][15 - i % 16], serial_out_second);
         chk("flag", i < 16, first_channel_flag);
         host_model_inst.tick();
         if (i % 16 == 15) begin
            host_model_inst.sel(1'b1);
            chk("flag_oe", 1'b0, first_channel_flag_oe);
         end
      end
      $display("test serial done");
      // reset in mid-run; the undefined select pair then reads as word mode
      @(negedge core_clk);
      srst = 1'b1;
      interface_select = 1'b0;
      byte_mode_select = 1'b1;
      repeat (3) @(negedge core_clk);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("busy", 1'b0, busy);
      chk("db_oe", 16'h0000, db_oe);
      load(7);
      rd(1'b1, channel_result[0], 16'hffff, 1'b1);
      rd(1'b1, channel_result[1], 16'hffff, 1'b0);
      $display("test reset done");
      stop_test();
   end

   // watchdog: the run needs about 77 us
   initial begin
      #400000;
      n_fail++;
      stop_test();
   end
endmodule // testbench
